// *** hdl/gate_ctrl.sv ***
// Three-phase gate command controller with fault and shutdown handling
//
// Overview of operation
// - Each leg keeps both commands low for at least 1.5 us before turning the complement on.
// - Every high and every low pulse on a gate command lasts at least 0.5 us, except one cut short when a fault or leaving run forces the leg off.
// - The carrier period is clamped so the PWM frequency never exceeds 20 kHz.
// - All six gate commands are always driven from flip-flops, never floated.
// - The shared fault line is open drain, pulled up outside, and a low level means fault.
// - The controller may pull the fault line low to force the driver outputs off.
// - After the fault line goes low all six commands go low well inside 5 ms.
// - On a fault the controller stops modulating and holds every command off.
// - After a fault stop the controller waits at least 2 s before commanding again.
// - An over-limit temperature reading stops operation like a fault.
`timescale 1ns/10ps
`default_nettype none
`include "gate_cfg.svh"
module gate_ctrl
	import gate_pkg::*;
#(
	parameter int unsigned RESTART_CYC = `RESTART_CYC
) (
	// Clock, reset, enable
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Operation control
	input  wire logic              run_en,
	input  wire logic              shutdown_req,
	input  wire logic [`CAR_W-1:0] carrier_period,
	input  wire logic [`CAR_W-1:0] duty_u,
	input  wire logic [`CAR_W-1:0] duty_v,
	input  wire logic [`CAR_W-1:0] duty_w,
	// Temperature from ADC
	input  wire logic [9:0]        temp_code,
	input  wire logic [9:0]        temp_limit,
	// Gate commands
	output logic [2:0]             high_side_command,
	output logic [2:0]             low_side_command,
	// Fault and shutdown line
	input  wire logic              fault_line_i,
	output logic                   fault_line_o,
	output logic                   fault_line_oe,
	// Status
	output logic                   running,
	output logic                   fault_stopped,
	output logic                   restart_wait,
	output logic                   overtemp_flag,
	output logic                   period_start,
	output logic [7:0]             fault_count
);

	localparam logic [`CAR_W-1:0]    PERIOD_MIN = `CAR_W'(`PERIOD_MIN_CYC);
	localparam logic [`SD_CNT_W-1:0] SD_LAST    = `SD_CNT_W'(`SD_CYC - 1);
	localparam logic [31:0]          WAIT_LAST  = 32'(RESTART_CYC - 1);

	// ==================================================================
	// Fault line input
	logic line_sync_ff;

	line_sync #(
		.RST_VAL (`LINE_IDLE)
	) u_line_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.pin_in   (fault_line_i),
		.level_ff (line_sync_ff)
	);

	wire line_low  = !line_sync_ff;
	wire hot       = (temp_code >= temp_limit);
	wire fault_now = line_low || hot;

	// ==================================================================
	// Shutdown drive on the fault line
	logic                  sd_oe_ff;
	logic [`SD_CNT_W-1:0]  sd_cnt_ff;
	wire                   sd_hold = sd_oe_ff && (sd_cnt_ff != SD_LAST);

	// Pull enable rises with the request and drops once the stretch has run out
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sd_oe_ff <= 1'b0;
		end else if (ce) begin
			if (shutdown_req) begin
				sd_oe_ff <= 1'b1;
			end else if (!sd_hold) begin
				sd_oe_ff <= 1'b0;
			end
		end
	end

	// Stretch counter keeps the pull on for at least 3 us after the request
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sd_cnt_ff <= '0;
		end else if (ce) begin
			if (shutdown_req) begin
				sd_cnt_ff <= '0;
			end else if (sd_hold) begin
				sd_cnt_ff <= sd_cnt_ff + 1'b1;
			end
		end
	end

	// ==================================================================
	// Control state machine
	ctl_state_t  state_ff;
	ctl_state_t  nxt_state;
	logic [31:0] wait_cnt_ff;
	wire         wait_done = (wait_cnt_ff == WAIT_LAST);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (fault_now) begin
					nxt_state = ST_STOP;
				end else if (run_en) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (fault_now) begin
					nxt_state = ST_STOP;
				end else if (!run_en) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_STOP: begin
				if (!fault_now) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (fault_now) begin
					nxt_state = ST_STOP;
				end else if (wait_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	wire enter_stop = (nxt_state == ST_STOP) && (state_ff != ST_STOP);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// Restart wait counter runs only while waiting, so a new fault restarts it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt_ff <= '0;
		end else if (ce) begin
			if (state_ff == ST_WAIT) begin
				wait_cnt_ff <= wait_cnt_ff + 32'h0000_0001;
			end else begin
				wait_cnt_ff <= '0;
			end
		end
	end

	// ==================================================================
	// Carrier and duty shadows
	logic [`CAR_W-1:0] car_cnt_ff;
	logic [`CAR_W-1:0] per_ff;
	logic [`CAR_W-1:0] duty_sh_ff [3];
	wire  [`CAR_W-1:0] per_clamped = (carrier_period < PERIOD_MIN) ? PERIOD_MIN
		: carrier_period;
	wire               car_wrap  = (car_cnt_ff >= per_ff - 1'b1);
	wire               modulate  = (state_ff == ST_RUN);
	wire               load_sh   = !modulate || car_wrap;

	// Carrier counter restarts at every wrap and whenever modulation is off
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			car_cnt_ff <= '0;
		end else if (ce) begin
			if (load_sh) begin
				car_cnt_ff <= '0;
			end else begin
				car_cnt_ff <= car_cnt_ff + 1'b1;
			end
		end
	end

	// Shadowed period and duties, so a mid-period change cannot cut a pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			per_ff        <= `PERIOD_RST;
			duty_sh_ff[0] <= `DUTY_RST;
			duty_sh_ff[1] <= `DUTY_RST;
			duty_sh_ff[2] <= `DUTY_RST;
		end else if (ce && load_sh) begin
			per_ff        <= per_clamped;
			duty_sh_ff[0] <= duty_u;
			duty_sh_ff[1] <= duty_v;
			duty_sh_ff[2] <= duty_w;
		end
	end

	// ==================================================================
	// Phase legs
	wire [2:0] leg_hs;
	wire [2:0] leg_ls;
	wire       force_off = !modulate || fault_now;

	for (genvar p = 0; p < 3; p++) begin : g_leg
		wire want_hi = (car_cnt_ff < duty_sh_ff[p]);

		phase_leg u_leg (
			.mclk      (mclk),
			.rst_n     (rst_n),
			.ce        (ce),
			.want_hi   (want_hi),
			.force_off (force_off),
			.hs_ff     (leg_hs[p]),
			.ls_ff     (leg_ls[p])
		);
	end

	assign high_side_command = leg_hs;
	assign low_side_command  = leg_ls;

	// ==================================================================
	// Status registers
	logic       line_o_ff;
	logic       run_ff;
	logic       stop_ff;
	logic       wait_ff;
	logic       hot_ff;
	logic       pstart_ff;
	logic [7:0] fcnt_ff;
	wire        nxt_run    = (nxt_state == ST_RUN);
	wire        nxt_stop   = (nxt_state == ST_STOP);
	wire        nxt_wait   = (nxt_state == ST_WAIT);
	wire        nxt_pstart = modulate && car_wrap;
	wire        fcnt_full  = (fcnt_ff == 8'hff);
	wire        fcnt_bump  = enter_stop && !fcnt_full;

	// Line output level: open drain, so only the enable ever moves
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			line_o_ff <= 1'b0;
		end else if (ce) begin
			line_o_ff <= 1'b0;
		end
	end

	// State flags follow the next state so they line up with the legs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff  <= 1'b0;
			stop_ff <= 1'b0;
			wait_ff <= 1'b0;
		end else if (ce) begin
			run_ff  <= nxt_run;
			stop_ff <= nxt_stop;
			wait_ff <= nxt_wait;
		end
	end

	// Overtemperature compare and carrier wrap pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hot_ff    <= 1'b0;
			pstart_ff <= 1'b0;
		end else if (ce) begin
			hot_ff    <= hot;
			pstart_ff <= nxt_pstart;
		end
	end

	// Fault counter saturates instead of wrapping
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fcnt_ff <= 8'h00;
		end else if (ce && fcnt_bump) begin
			fcnt_ff <= fcnt_ff + 8'h01;
		end
	end

	assign fault_line_o  = line_o_ff;
	assign fault_line_oe = sd_oe_ff;
	assign running       = run_ff;
	assign fault_stopped = stop_ff;
	assign restart_wait  = wait_ff;
	assign overtemp_flag = hot_ff;
	assign period_start  = pstart_ff;
	assign fault_count   = fcnt_ff;

endmodule
`default_nettype wire

// *** shared/gate_cfg.svh ***
// Timing constants and reset values for the three-phase gate command controller
`ifndef GATE_CFG_SVH
`define GATE_CFG_SVH

// ==========================================================================
// Clock
`define MCLK_HZ 40000000
`define MCLK_MHZ 40

// ==========================================================================
// Gate command timing
`define DEAD_NS 1500
`define DEAD_CYC ((`DEAD_NS * `MCLK_MHZ + 999) / 1000)
`define MINP_NS 500
`define MINP_CYC ((`MINP_NS * `MCLK_MHZ + 999) / 1000)
`define CARRIER_MAX_HZ 20000
`define PERIOD_MIN_CYC ((`MCLK_HZ + `CARRIER_MAX_HZ - 1) / `CARRIER_MAX_HZ)
`define LEG_CNT_W 7
`define CAR_W 12

// ==========================================================================
// Fault handling timing
`define RESTART_S 2
`define RESTART_CYC (`RESTART_S * `MCLK_HZ)
`define SD_PULSE_NS 3000
`define SD_CYC ((`SD_PULSE_NS * `MCLK_MHZ + 999) / 1000)
`define SD_CNT_W 8

// ==========================================================================
// Reset values
`define PERIOD_RST 12'hfa0
`define DUTY_RST 12'h000
`define LINE_IDLE 1'b1

`endif

// *** shared/gate_pkg.sv ***
// Types shared by the gate command controller modules
package gate_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RUN  = 4'b0010,
		ST_STOP = 4'b0100,
		ST_WAIT = 4'b1000
	} ctl_state_t;

	typedef enum logic [2:0] {
		LEG_OFF = 3'b001,
		LEG_HI  = 3'b010,
		LEG_LO  = 3'b100
	} leg_state_t;

endpackage

// *** hdl/line_sync.sv ***
// Two-flop synchroniser for an asynchronous pin level
`timescale 1ns/10ps
`default_nettype none
module line_sync
	import gate_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Level
	input  wire logic pin_in,
	output logic      level_ff
);

	logic meta_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff  <= RST_VAL;
			level_ff <= RST_VAL;
		end else if (ce) begin
			meta_ff  <= pin_in;
			level_ff <= meta_ff;
		end
	end

endmodule
`default_nettype wire

// *** hdl/phase_leg.sv ***
// One phase leg: complementary commands with dead time and minimum pulse width
`timescale 1ns/10ps
`default_nettype none
`include "gate_cfg.svh"
module phase_leg
	import gate_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Request
	input  wire logic want_hi,
	input  wire logic force_off,
	// Gate commands
	output logic      hs_ff,
	output logic      ls_ff
);

	localparam logic [`LEG_CNT_W-1:0] DEAD = `LEG_CNT_W'(`DEAD_CYC);
	localparam logic [`LEG_CNT_W-1:0] MINP = `LEG_CNT_W'(`MINP_CYC);

	leg_state_t             leg_ff;
	leg_state_t             nxt_leg;
	logic [`LEG_CNT_W-1:0]  cnt_ff;
	wire                    dead_done = (cnt_ff >= DEAD);
	wire                    minp_done = (cnt_ff >= MINP);
	wire                    changing  = (nxt_leg != leg_ff);

	// ==================================================================
	// Leg sequencing
	always_comb begin
		nxt_leg = leg_ff;
		case (leg_ff)
			LEG_OFF: begin
				if (!force_off && dead_done) begin
					nxt_leg = want_hi ? LEG_HI : LEG_LO;
				end
			end
			LEG_HI: begin
				if (force_off || (!want_hi && minp_done)) begin
					nxt_leg = LEG_OFF;
				end
			end
			LEG_LO: begin
				if (force_off || (want_hi && minp_done)) begin
					nxt_leg = LEG_OFF;
				end
			end
			default: begin
				nxt_leg = LEG_OFF;
			end
		endcase
	end

	// ==================================================================
	// State, time since last edge, registered commands
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			leg_ff <= LEG_OFF;
			cnt_ff <= '0;
			hs_ff  <= 1'b0;
			ls_ff  <= 1'b0;
		end else if (ce) begin
			leg_ff <= nxt_leg;
			if (changing) begin
				cnt_ff <= '0;
			end else if (!dead_done) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
			hs_ff <= (nxt_leg == LEG_HI);
			ls_ff <= (nxt_leg == LEG_LO);
		end
	end

endmodule
`default_nettype wire

// *** bench/inverter_drv_model.sv ***
// Behavioural model of the inverter driver pins
`timescale 1ns/10ps
`default_nettype none
module inverter_drv_model (
	input  wire logic [2:0] high_side_command,
	input  wire logic [2:0] low_side_command,
	input  wire logic       fault_line_oe,
	input  wire logic       fault_pull,
	output logic            fault_line,
	output logic [2:0]      hs_on,
	output logic [2:0]      ls_on
);
	always_comb begin
		fault_line = !(fault_line_oe || fault_pull);
		for (int i = 0; i < 3; i++) begin
			hs_on[i] = fault_line && (high_side_command[i] === 1'b1);
			ls_on[i] = fault_line && (low_side_command[i] === 1'b1);
		end
	end
endmodule
`default_nettype wire

// *** bench/gate_ctrl_asserts.sv ***
// Assertion checker for the gate command controller
`timescale 1ns/10ps
`default_nettype none
module gate_ctrl_chk #(
	parameter int unsigned RESTART_CYC = 200
) (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       shutdown_req,
	input wire logic [9:0] temp_code,
	input wire logic [9:0] temp_limit,
	input wire logic [2:0] high_side_command,
	input wire logic [2:0] low_side_command,
	input wire logic       fault_line_i,
	input wire logic       fault_line_o,
	input wire logic       fault_line_oe,
	input wire logic       running,
	input wire logic       fault_stopped,
	input wire logic       restart_wait,
	input wire logic       period_start
);
	logic [7:0]  off_ff;
	logic [7:0]  hi_ff;
	logic [15:0] ps_ff;
	logic [31:0] w_ff;
	wire logic   hs0 = high_side_command[0];
	wire logic   quiet = (high_side_command | low_side_command) == 3'h0;
	// ==========================================================
	// Cycle counters
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			off_ff <= 8'h00;
			hi_ff <= 8'h00;
			ps_ff <= 16'h0000;
			w_ff <= 32'h0;
		end else begin
			off_ff <= (hs0 | low_side_command[0]) ? 8'h00 : off_ff + {7'h0, off_ff != 8'hff};
			hi_ff <= hs0 ? hi_ff + {7'h0, hi_ff != 8'hff} : 8'h00;
			ps_ff <= period_start ? 16'h0000 : ps_ff + {15'h0, ps_ff != 16'hffff};
			w_ff <= restart_wait ? w_ff + 32'h1 : 32'h0;
		end
	end
	// ==========================================================
	// Properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_no_overlap; (high_side_command & low_side_command) == 3'h0; endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both sides on");
	property p_dead; $rose(hs0) || $rose(low_side_command[0]) |-> off_ff >= 8'h3c; endproperty
	a_dead: assert property (p_dead) else $error("dead time short");
	property p_minp; $fell(hs0) && running |-> hi_ff >= 8'h14; endproperty
	a_minp: assert property (p_minp) else $error("pulse short");
	property p_car; period_start |-> ps_ff >= 16'h07cf; endproperty
	a_car: assert property (p_car) else $error("carrier too fast");
	property p_od; fault_line_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("line driven high");
	property p_react; $fell(fault_line_i) |-> ##[1:5] quiet; endproperty
	a_react: assert property (p_react) else $error("slow fault reaction");
	property p_hold; fault_stopped || restart_wait |-> quiet; endproperty
	a_hold: assert property (p_hold) else $error("commands while stopped");
	property p_wait; $fell(restart_wait) && !fault_stopped |-> w_ff >= RESTART_CYC; endproperty
	a_wait: assert property (p_wait) else $error("restart too early");
	property p_start; $rose(running) |-> !$past(restart_wait) && !$past(fault_stopped) && quiet;
	endproperty
	a_start: assert property (p_start) else $error("bad run entry");
	property p_sync; running && $fell(fault_line_i) |=> running; endproperty
	a_sync: assert property (p_sync) else $error("fault not synchronised");
	property p_sd; $rose(shutdown_req) |=> fault_line_oe; endproperty
	a_sd: assert property (p_sd) else $error("no shutdown pull");
	property p_sdh; $fell(shutdown_req) |-> ##118 fault_line_oe; endproperty
	a_sdh: assert property (p_sdh) else $error("shutdown pull short");
	property p_hot; running && temp_code >= temp_limit |-> ##[1:4] quiet; endproperty
	a_hot: assert property (p_hot) else $error("hot not stopped");
	c_fault: cover property ($rose(fault_stopped));
	c_resume: cover property ($fell(restart_wait));
	c_wrap: cover property (period_start);
endmodule
bind gate_ctrl gate_ctrl_chk #(.RESTART_CYC(RESTART_CYC)) chk_u (.mclk, .rst_n, .shutdown_req,
	.temp_code, .temp_limit, .high_side_command, .low_side_command, .fault_line_i,
	.fault_line_o, .fault_line_oe, .running, .fault_stopped, .restart_wait, .period_start);
`default_nettype wire

// *** bench/gate_ctrl_bench.sv ***
// Self-checking testbench for the gate command controller
`timescale 1ns/10ps
`default_nettype none
`include "gate_cfg.svh"
module gate_ctrl_bench;
	localparam int unsigned RS = 200;
	logic              mclk, rst_n, run_en, shutdown_req, fault_pull, fault_line;
	logic [`CAR_W-1:0] carrier_period, duty_u, duty_v, duty_w;
	logic [9:0]        temp_code, temp_limit;
	logic [2:0]        high_side_command, low_side_command, hs_on, ls_on;
	logic              fault_line_oe, running, fault_stopped, restart_wait;
	logic              overtemp_flag, period_start;
	logic [7:0]        fault_count;
	int                mismatches, comparisons, n;
	wire logic [5:0]   cmds = {high_side_command, low_side_command};
	gate_ctrl #(.RESTART_CYC(RS)) dut_u (.mclk, .rst_n, .ce(1'b1), .run_en, .shutdown_req,
		.carrier_period, .duty_u, .duty_v, .duty_w, .temp_code, .temp_limit,
		.high_side_command, .low_side_command, .fault_line_i(fault_line), .fault_line_o(),
		.fault_line_oe, .running, .fault_stopped, .restart_wait, .overtemp_flag,
		.period_start, .fault_count);
	inverter_drv_model drv_u (.high_side_command, .low_side_command, .fault_line_oe,
		.fault_pull, .fault_line, .hs_on, .ls_on);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ==========================================================
	// Shared tasks
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic recover;
		n = 0;
		while (n < 400 && restart_wait !== 1'b1) begin tick(1); n++; end
		chk("wait quiet", 6'h00, cmds);
		n = 0;
		while (n < 1000 && restart_wait === 1'b1) begin tick(1); n++; end
		chk("wait length", 1, n >= RS);
		tick(2);
		chk("resumed", 1, running);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_run;
		chk("reset quiet", 6'h00, cmds);
		chk("line idle", 1, fault_line);
		run_en = 1'b1;
		tick(1);
		chk("running", 1, running);
		n = 0;
		while (n < 3000 && period_start !== 1'b1) begin tick(1); n++; end
		n = 0;
		do begin tick(1); n++; end while (n < 3000 && period_start !== 1'b1);
		chk("carrier", 2000, n);
		chk("w low on", 1, ls_on[2]);
		n = 0;
		while (n < 4000 && high_side_command[0] !== 1'b1) begin tick(1); n++; end
		n = 0;
		while (n < 100 && high_side_command[0] === 1'b1) begin tick(1); n++; end
		chk("u pulse", 1, n >= 20);
	endtask
	task automatic t_fault;
		fault_pull = 1'b1;
		n = 0;
		while (n < 10 && cmds !== 6'h00) begin tick(1); n++; end
		chk("fault reaction", 1, n <= 5);
		tick(2);
		chk("stopped", 1, fault_stopped);
		chk("transistors", 6'h00, {hs_on, ls_on});
		chk("fault count", 8'h01, fault_count);
		fault_pull = 1'b0;
		recover;
	endtask
	task automatic t_shutdown;
		shutdown_req = 1'b1;
		tick(1);
		chk("pull", 1, fault_line_oe);
		shutdown_req = 1'b0;
		tick(100);
		chk("pull held", 1, fault_line_oe);
		chk("self stop", 1, fault_stopped);
		recover;
	endtask
	task automatic t_hot;
		temp_limit = 10'h200;
		temp_code = 10'h1ff;
		tick(3);
		chk("cool run", 1, running);
		temp_code = 10'h200;
		tick(4);
		chk("hot quiet", 6'h00, cmds);
		chk("hot flag", 1, overtemp_flag);
		chk("hot count", 8'h03, fault_count);
		temp_code = 10'h100;
		recover;
	endtask
	initial begin
		mismatches = 0;
		comparisons = 0;
		{rst_n, run_en, shutdown_req, fault_pull} = 4'h0;
		carrier_period = 12'h064;
		{duty_u, duty_v, duty_w} = {12'h050, 12'h3e8, 12'h000};
		temp_code = 10'h000;
		temp_limit = 10'h3ff;
		repeat (4) @(posedge mclk);
		#2 rst_n = 1'b1;
		tick(1);
		t_run;
		t_fault;
		t_shutdown;
		t_hot;
		close_out;
	end
	initial begin
		#(25 * 40000);
		mismatches++;
		close_out;
	end
endmodule
`default_nettype wire
